// [ctrsc_buffer_write_pointer.sv]
module ctrsc_buffer_write_pointer
  import ctrsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic [8:0] depth_n,
  input wire logic inc,
  input wire logic dec,
  // state
  output logic [7:0] ptr
);
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [7:0] last;

  always_comb
  begin
    last = 8'(depth_n - 9'h001);
    ptr_d = ptr_q & last;
    if (inc)
      ptr_d = ((ptr_q & last) == last) ? 8'h00 : 8'((ptr_q & last) + 8'h01);
    else if (dec)
      ptr_d = ((ptr_q & last) == 8'h00) ? last : 8'((ptr_q & last) - 8'h01);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ptr_q <= 8'h00;
    else
      ptr_q <= ptr_d;
  end

  assign ptr = ptr_q;
endmodule

// [ctrsc_depth.sv]
module ctrsc_depth
  import ctrsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // write
  input wire logic wr_en,
  input wire logic [2:0] wr_val,
  // state
  output logic [2:0] depth_enc,
  output logic [8:0] depth_n
);
  logic [2:0] depth_q;
  logic [2:0] depth_d;
  logic [7:0] supported;

  // padded to all eight codes so the reserved ones index a defined zero
  assign supported = {3'h0, CTRSC_DEPTH_SUPPORTED};

  always_comb
  begin
    depth_d = depth_q;
    // reserved or unsupported encodings keep the old value
    if (wr_en && wr_val <= 3'h4 && supported[wr_val])
      depth_d = wr_val;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      depth_q <= CTRSC_DEPTH_RESET;
    else
      depth_q <= depth_d;
  end

  assign depth_enc = depth_q;
  assign depth_n = 9'h010 << depth_q;
endmodule

// [ctrsc_hart_model.sv]
module ctrsc_hart_model
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // frozen flag
  input wire logic freeze_set,
  input wire logic unfreeze,
  output logic frozen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic frozen_q, frozen_d;
  // set wins over clear so a freeze is never lost
  always_comb
  begin
    frozen_d = frozen_q;
    if (freeze_set)
      frozen_d = 1'b1;
    else if (unfreeze)
      frozen_d = 1'b0;
  end
  always_ff @(posedge clk)
    frozen_q <= sys_rst ? 1'b0 : frozen_d;
  assign frozen = frozen_q;
endmodule

// [ctrsc_pkg.sv]
package ctrsc_pkg;
  // privilege modes as seen by the block
  typedef enum logic [2:0] {
    CTRSC_PRIV_U = 3'b001,
    CTRSC_PRIV_S = 3'b010,
    CTRSC_PRIV_M = 3'b100
  } ctrsc_priv_e;

  // which register a csr access targets
  typedef enum logic [2:0] {
    CTRSC_SEL_CTL = 3'b001,
    CTRSC_SEL_VCTL = 3'b010,
    CTRSC_SEL_DEPTH = 3'b100
  } ctrsc_sel_e;

  // control register field positions
  localparam int CTRSC_U_BIT = 0;
  localparam int CTRSC_S_BIT = 1;
  localparam int CTRSC_M_BIT = 2;
  localparam int CTRSC_STE_BIT = 8;
  localparam int CTRSC_MTE_BIT = 9;
  localparam int CTRSC_BPHALT_BIT = 11;
  localparam int CTRSC_LCOHALT_BIT = 12;
  localparam int CTRSC_RETURN_STACK_EMULATION_BIT = 7;
  localparam logic [63:0] CTRSC_CTL_IMPL_MASK = 64'hF000_FFFE_0000_1B87;
  localparam logic [63:0] CTRSC_SUP_MASK = 64'hF000_FFFE_0000_1983;
  localparam logic [63:0] CTRSC_CTL_RESET = 64'h0000_0000_0000_0000;

  // depth register
  localparam int CTRSC_DEPTH_W = 3;
  localparam logic [2:0] CTRSC_DEPTH_RESET = 3'h0;
  localparam logic [4:0] CTRSC_DEPTH_SUPPORTED = 5'h1F;
  localparam int CTRSC_PTR_W = 8;

  typedef struct packed {
    logic valid;
    logic write;
    ctrsc_sel_e sel;
    logic [63:0] wdata;
  } ctrsc_csr_req_s;

  typedef struct packed {
    logic [63:0] rdata;
    logic virt_instr_fault;
  } ctrsc_csr_rsp_s;

  typedef struct packed {
    logic trap_valid;
    ctrsc_priv_e trap_target;
    logic trap_virt;
    logic trap_breakpoint;
    logic trap_counter_overflow;
  } ctrsc_trap_s;
endpackage

// [ctrsc_regs.sv]
module ctrsc_regs
  import ctrsc_pkg::*;
#(
  parameter bit HAS_HYP = 1'b1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // hart state
  input ctrsc_pkg::ctrsc_priv_e priv,
  input wire logic virt,
  input wire logic stateen_block,
  // csr access
  input ctrsc_pkg::ctrsc_csr_req_s csr_req,
  output ctrsc_pkg::ctrsc_csr_rsp_s csr_rsp,
  // machine control access
  input wire logic mctl_wr,
  input wire logic [63:0] mctl_wdata,
  output logic [63:0] mctl_rdata,
  // traps and transfers
  input ctrsc_pkg::ctrsc_trap_s trap,
  input wire logic xfer_valid,
  input wire logic xfer_pop,
  // frozen flag
  input wire logic frozen_in,
  output logic freeze_set,
  // entry access
  input wire logic [7:0] entry_idx,
  output logic entry_in_range,
  // recording state
  output logic record_active,
  output logic record_trap,
  output logic [7:0] wr_ptr,
  output logic [2:0] depth_enc,
  output logic return_stack_emulation
);
  import ctrsc_pkg::*;

  logic [63:0] mctl_q;
  logic [63:0] mctl_d;
  logic [63:0] vctl_q;
  logic [63:0] vctl_d;
  logic [63:0] ctl_eff;
  logic [63:0] rdata;
  logic depth_wr;
  logic depth_fault;
  logic [8:0] depth_n;
  logic mode_en;
  logic trap_en;
  logic bp_halt;
  logic lco_halt;
  logic rec_ok;

  // depth writes from guest modes are refused, with a fault unless stateen_block is set
  assign depth_fault = virt && !stateen_block && csr_req.valid && csr_req.sel == CTRSC_SEL_DEPTH;
  assign depth_wr = csr_req.valid && csr_req.write && csr_req.sel == CTRSC_SEL_DEPTH && !virt;

  ctrsc_depth u_depth (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(depth_wr),
    .wr_val(csr_req.wdata[2:0]),
    .depth_enc(depth_enc),
    .depth_n(depth_n)
  );

  always_comb
  begin
    mctl_d = mctl_q;
    vctl_d = vctl_q;
    if (mctl_wr)
      mctl_d = mctl_wdata & CTRSC_CTL_IMPL_MASK;
    if (csr_req.valid && csr_req.write)
    begin
      if (csr_req.sel == CTRSC_SEL_CTL && !(virt && HAS_HYP))
        mctl_d = (mctl_q & ~CTRSC_SUP_MASK) | (csr_req.wdata & CTRSC_SUP_MASK);
      // guest keeps the same field set as the supervisor view
      else if (HAS_HYP && ((csr_req.sel == CTRSC_SEL_CTL && virt) || csr_req.sel == CTRSC_SEL_VCTL))
        vctl_d = csr_req.wdata & CTRSC_SUP_MASK;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mctl_q <= CTRSC_CTL_RESET;
      vctl_q <= CTRSC_CTL_RESET;
    end
    else
    begin
      mctl_q <= mctl_d;
      vctl_q <= vctl_d;
    end
  end

  always_comb
  begin
    rdata = 64'h0;
    unique case (csr_req.sel)
      CTRSC_SEL_CTL:
        rdata = (virt && HAS_HYP) ? vctl_q : (mctl_q & CTRSC_SUP_MASK);
      CTRSC_SEL_VCTL:
        rdata = HAS_HYP ? vctl_q : 64'h0;
      CTRSC_SEL_DEPTH:
        rdata = {61'h0, depth_enc};
      default:
        rdata = 64'h0;
    endcase
  end

  assign csr_rsp.rdata = depth_fault ? 64'h0 : rdata;
  assign csr_rsp.virt_instr_fault = depth_fault;
  assign mctl_rdata = mctl_q;

  // guest control sets the U and S mode bits and the return-stack bit only while virtualization is on; S-target traps with trap_virt use it always
  assign ctl_eff = (virt && HAS_HYP) ? vctl_q : mctl_q;

  always_comb
  begin
    mode_en = 1'b0;
    unique case (priv)
      CTRSC_PRIV_U: mode_en = ctl_eff[CTRSC_U_BIT];
      CTRSC_PRIV_S: mode_en = ctl_eff[CTRSC_S_BIT];
      CTRSC_PRIV_M: mode_en = mctl_q[CTRSC_M_BIT];
      default: mode_en = 1'b0;
    endcase
  end

  always_comb
  begin
    trap_en = 1'b0;
    bp_halt = 1'b0;
    lco_halt = 1'b0;
    if (trap.trap_valid)
    begin
      unique case (trap.trap_target)
        CTRSC_PRIV_M:
        begin
          trap_en = mctl_q[CTRSC_M_BIT] | mctl_q[CTRSC_MTE_BIT];
          bp_halt = mctl_q[CTRSC_BPHALT_BIT];
          lco_halt = mctl_q[CTRSC_LCOHALT_BIT];
        end
        CTRSC_PRIV_S:
        begin
          // trap target virt selects the guest copy
          trap_en = trap.trap_virt ? (vctl_q[CTRSC_S_BIT] | vctl_q[CTRSC_STE_BIT])
                                   : (mctl_q[CTRSC_S_BIT] | mctl_q[CTRSC_STE_BIT]);
          bp_halt = trap.trap_virt ? vctl_q[CTRSC_BPHALT_BIT] : mctl_q[CTRSC_BPHALT_BIT];
          lco_halt = trap.trap_virt ? vctl_q[CTRSC_LCOHALT_BIT] : mctl_q[CTRSC_LCOHALT_BIT];
        end
        default:
        begin
          trap_en = 1'b0;
        end
      endcase
    end
  end

  assign freeze_set = (bp_halt && trap.trap_breakpoint) || (lco_halt && trap.trap_counter_overflow);
  assign record_active = mode_en && !frozen_in;
  assign record_trap = trap_en && !frozen_in && trap.trap_valid;
  assign return_stack_emulation = ctl_eff[CTRSC_RETURN_STACK_EMULATION_BIT];
  assign rec_ok = !frozen_in && (mode_en || trap_en);

  // pointer stays inside 0..depth-1 from one cycle after a depth change; entries at depth and above report entry_in_range low
  ctrsc_buffer_write_pointer u_buffer_write_pointer (
    .clk(clk),
    .sys_rst(sys_rst),
    .depth_n(depth_n),
    .inc(xfer_valid && rec_ok && !xfer_pop),
    .dec(xfer_valid && rec_ok && xfer_pop && return_stack_emulation),
    .ptr(wr_ptr)
  );

  assign entry_in_range = {1'b0, entry_idx} < depth_n;
endmodule

// [ctrsc_regs_monitor.sv]
module ctrsc_regs_monitor
  import ctrsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // watched
  input wire logic virt,
  input wire logic stateen_block,
  input ctrsc_pkg::ctrsc_csr_req_s csr_req,
  input ctrsc_pkg::ctrsc_csr_rsp_s csr_rsp,
  input wire logic [63:0] mctl_rdata,
  input wire logic frozen_in,
  input wire logic [7:0] entry_idx,
  input wire logic entry_in_range,
  input wire logic record_active,
  input wire logic [7:0] wr_ptr,
  input wire logic [2:0] depth_enc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ctl_rd, dep_acc, dep_wr;
  assign ctl_rd = csr_req.valid && !csr_req.write && csr_req.sel == CTRSC_SEL_CTL && !virt;
  assign dep_acc = csr_req.valid && csr_req.sel == CTRSC_SEL_DEPTH;
  assign dep_wr = dep_acc && csr_req.write && !virt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_dep_legal;
    dep_wr && csr_req.wdata[2:0] <= 3'h4;
  endsequence
  sequence s_dep_rsvd;
    dep_wr && csr_req.wdata[2:0] > 3'h4;
  endsequence
  a_sup_hides_mbits: assert property (ctl_rd |-> !csr_rsp.rdata[2] && !csr_rsp.rdata[9])
    else $error("machine bits seen in supervisor view");
  a_sup_shares: assert property (ctl_rd |-> csr_rsp.rdata == (mctl_rdata & CTRSC_SUP_MASK))
    else $error("supervisor view differs from machine state");
  a_depth_read: assert property (dep_acc && !csr_req.write && !virt |-> csr_rsp.rdata == {61'h0, depth_enc})
    else $error("depth read wrong");
  a_depth_take: assert property (s_dep_legal |=> depth_enc == $past(csr_req.wdata[2:0]))
    else $error("legal depth not taken");
  a_depth_keep: assert property (s_dep_rsvd |=> $stable(depth_enc))
    else $error("reserved depth taken");
  a_depth_legal: assert property (depth_enc <= 3'h4)
    else $error("depth field illegal");
  a_vs_fault: assert property (dep_acc && virt && !stateen_block |-> csr_rsp.virt_instr_fault)
    else $error("guest depth access not faulted");
  a_host_no_fault: assert property (dep_acc && !virt |-> !csr_rsp.virt_instr_fault)
    else $error("host depth access faulted");
  a_entry_range: assert property (entry_in_range == ({1'b0, entry_idx} < (9'h010 << depth_enc)))
    else $error("entry range wrong");
  // pointer is re-masked one cycle after a depth change
  a_ptr_bound: assert property ($stable(depth_enc) |-> {1'b0, wr_ptr} < (9'h010 << depth_enc))
    else $error("pointer beyond depth");
  a_frozen_idle: assert property (frozen_in |-> !record_active)
    else $error("recording while frozen");
endmodule

// [ctrsc_regs_tb.sv]
module ctrsc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ctrsc_pkg::*;
  logic clk = 0, sys_rst = 1, virt = 0, stateen_block = 0, mctl_wr = 0, xfer_valid = 0, xfer_pop = 0;
  logic unfreeze = 0, frozen_in, freeze_set, entry_in_range, record_active, record_trap, return_stack_emulation;
  ctrsc_priv_e priv = CTRSC_PRIV_S;
  ctrsc_csr_req_s csr_req = '0;
  ctrsc_csr_rsp_s csr_rsp;
  ctrsc_trap_s trap = '0;
  logic [63:0] mctl_wdata = '0, mctl_rdata;
  logic [7:0] entry_idx = '0, wr_ptr;
  logic [2:0] depth_enc;
  int fail_count = 0, checked = 0;

  ctrsc_regs ctrsc_regs_inst (.clk, .sys_rst, .priv, .virt, .stateen_block, .csr_req, .csr_rsp, .mctl_wr,
    .mctl_wdata, .mctl_rdata, .trap, .xfer_valid, .xfer_pop, .frozen_in, .freeze_set, .entry_idx,
    .entry_in_range, .record_active, .record_trap, .wr_ptr, .depth_enc, .return_stack_emulation);
  ctrsc_hart_model ctrsc_hart_model_inst (.clk, .sys_rst, .freeze_set, .unfreeze, .frozen(frozen_in));

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({63'h0, got}, {63'h0, exp});
  endtask
  // request dropped after its edge; one idle edge keeps calls apart
  task automatic csr(input logic wr, input ctrsc_sel_e sel, input logic [63:0] d);
    csr_req = '{1'b1, wr, sel, d};
    #1;
    if (!wr)
      chk(csr_rsp.rdata, d);
    step();
    csr_req = '0;
    step();
  endtask
  task automatic mwr(input logic [63:0] d);
    mctl_wr = 1;
    mctl_wdata = d;
    step();
    mctl_wr = 0;
  endtask
  task automatic trp(input ctrsc_trap_s t, input logic rec, input logic frz);
    trap = t;
    #1;
    chk({62'h0, record_trap, freeze_set}, {62'h0, rec, frz});
    step();
    trap = '0;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #10us;
    fail_count++;
    finish_test();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 0;
    chk({56'h0, wr_ptr}, 64'h0);
    csr(0, CTRSC_SEL_DEPTH, 64'h0);
    csr(1, CTRSC_SEL_CTL, '1);
    csr(0, CTRSC_SEL_CTL, CTRSC_SUP_MASK);
    chk(mctl_rdata, CTRSC_SUP_MASK);
    mwr('1);
    csr(0, CTRSC_SEL_CTL, CTRSC_SUP_MASK);
    virt = 1;
    csr(1, CTRSC_SEL_CTL, 64'h3);
    csr(0, CTRSC_SEL_VCTL, 64'h3);
    chk(mctl_rdata, CTRSC_CTL_IMPL_MASK);
    csr(1, CTRSC_SEL_VCTL, '1);
    csr(0, CTRSC_SEL_CTL, CTRSC_SUP_MASK);
    csr(1, CTRSC_SEL_VCTL, 64'h2);
    mwr(64'h0);
    chk1(record_active, 1);
    priv = CTRSC_PRIV_U;
    step();
    chk1(record_active, 0);
    virt = 0;
    priv = CTRSC_PRIV_S;
    step();
    chk1(record_active, 0);
    csr(1, CTRSC_SEL_VCTL, 64'h100);
    virt = 1;
    trp('{1'b1, CTRSC_PRIV_S, 1'b1, 1'b0, 1'b0}, 1, 0);
    virt = 0;
    mwr(64'h200);
    trp('{1'b1, CTRSC_PRIV_M, 1'b0, 1'b0, 1'b0}, 1, 0);
    virt = 1;
    csr(1, CTRSC_SEL_VCTL, 64'h800);
    trp('{1'b1, CTRSC_PRIV_S, 1'b1, 1'b1, 1'b0}, 0, 1);
    csr(1, CTRSC_SEL_VCTL, 64'h2);
    chk1(record_active, 0);
    unfreeze = 1;
    step();
    unfreeze = 0;
    chk1(record_active, 1);
    csr(1, CTRSC_SEL_VCTL, 64'h1000);
    trp('{1'b1, CTRSC_PRIV_S, 1'b1, 1'b0, 1'b1}, 0, 1);
    virt = 0;
    unfreeze = 1;
    for (int i = 0; i < 5; i++)
    begin
      csr(1, CTRSC_SEL_DEPTH, 64'hFFF8 | 64'(i));
      csr(0, CTRSC_SEL_DEPTH, 64'(i));
      entry_idx = 8'((16 << i) - 1);
      step();
      chk1(entry_in_range, 1);
      entry_idx = 8'(16 << i);
      step();
      chk1(entry_in_range, i == 4);
    end
    unfreeze = 0;
    csr(1, CTRSC_SEL_DEPTH, 64'h6);
    csr(0, CTRSC_SEL_DEPTH, 64'h4);
    csr(1, CTRSC_SEL_DEPTH, 64'h0);
    virt = 1;
    csr_req = '{1'b1, 1'b1, CTRSC_SEL_DEPTH, 64'h2};
    #1;
    chk1(csr_rsp.virt_instr_fault, 1);
    step();
    stateen_block = 1;
    #1;
    chk1(csr_rsp.virt_instr_fault, 0);
    step();
    csr_req = '0;
    stateen_block = 0;
    virt = 0;
    step();
    csr(0, CTRSC_SEL_DEPTH, 64'h0);
    mwr(64'h2);
    xfer_valid = 1;
    repeat (17) step();
    xfer_valid = 0;
    chk({56'h0, wr_ptr}, 64'h1);
    mwr(64'h82);
    chk1(return_stack_emulation, 1);
    xfer_valid = 1;
    xfer_pop = 1;
    repeat (2) step();
    xfer_valid = 0;
    xfer_pop = 0;
    chk({56'h0, wr_ptr}, 64'hF);
    finish_test();
  end
endmodule

bind ctrsc_regs ctrsc_regs_monitor ctrsc_regs_monitor_inst (.clk, .sys_rst, .virt, .stateen_block, .csr_req,
  .csr_rsp, .mctl_rdata, .frozen_in, .entry_idx, .entry_in_range, .record_active, .wr_ptr, .depth_enc);
